// ---- rtl/adc_front_pkg.sv ----
package adc_front_pkg;

	// ****************************************
	// Register map (word index = byte address)
	// ****************************************
	localparam logic [3:0] STATUS_CTRL_ADDR = 4'h0;
	localparam logic [3:0] CONFIG_ADDR = 4'h1;
	localparam logic [3:0] TRIGGER_CTRL_ADDR = 4'h2;
	localparam logic [3:0] RESULT_HIGH_ADDR = 4'h3;
	localparam logic [3:0] RESULT_LOW_ADDR = 4'h4;
	localparam logic [3:0] COMPARE_HIGH_ADDR = 4'h5;
	localparam logic [3:0] COMPARE_LOW_ADDR = 4'h6;
	localparam logic [3:0] PIN_DISABLE_HIGH_ADDR = 4'h7;

	// ****************************************
	// Field codes
	// ****************************************
	localparam logic [4:0] CHANNEL_ALL_ONES = 5'h1F;
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;
	localparam logic [1:0] CLKSRC_BUS = 2'h0;
	localparam logic [1:0] CLKSRC_BUS_HALF = 2'h1;
	localparam logic [1:0] CLKSRC_ALT = 2'h2;
	localparam logic [1:0] CLKSRC_ASYNC = 2'h3;
	localparam logic [1:0] DIV_BY_1 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_4 = 2'h2;
	localparam logic [1:0] DIV_BY_8 = 2'h3;
	localparam int FIRST_PIN_CHANNEL = 16;
	localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_MHZ = 125;
	localparam int ASYNC_STARTUP_NS = 5000;
	localparam int ASYNC_STARTUP_CYCLES = (ASYNC_STARTUP_NS * CLOCK_MHZ + 999) / 1000;
	localparam int RAW_BITS_10 = 11;
	localparam int RAW_BITS_8 = 9;

	typedef struct packed
	{
		logic continuous;
		logic irqEnable;
		logic [4:0] channel;
	} status_ctrl_type;

	typedef struct packed
	{
		logic [1:0] divider;
		logic [1:0] mode;
		logic [1:0] source;
	} config_type;

	typedef struct packed
	{
		logic compareEnable;
		logic greaterEqual;
		logic hardwareTrigger;
	} trigger_ctrl_type;

endpackage : adc_front_pkg

// ---- rtl/clock_divider.sv ----
`timescale 1ns/1ps
module clock_divider
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic halfSource,
	input wire logic [1:0] divider,
	input wire logic sourceTick,
	// Converter clock enable
	output logic convTick
);

	logic halfToggle_reg;
	logic [2:0] count_reg;
	logic [2:0] limit;
	logic stageTick;

	assign stageTick = sourceTick && (!halfSource || halfToggle_reg);

	always_comb
	begin
		case (divider)
			adc_front_pkg::DIV_BY_1: limit = 3'h0;
			adc_front_pkg::DIV_BY_2: limit = 3'h1;
			adc_front_pkg::DIV_BY_4: limit = 3'h3;
			default: limit = 3'h7;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			halfToggle_reg <= 1'b0;
		else if (!run)
			halfToggle_reg <= 1'b0;
		else if (sourceTick)
			halfToggle_reg <= !halfToggle_reg;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= 3'h0;
			convTick <= 1'b0;
		end
		else
		begin
			convTick <= 1'b0;
			if (!run)
				count_reg <= 3'h0;
			else if (stageTick)
			begin
				if (count_reg >= limit)
				begin
					count_reg <= 3'h0;
					convTick <= 1'b1;
				end
				else
					count_reg <= count_reg + 3'h1;
			end
		end
	end

endmodule : clock_divider

// ---- rtl/trigger_sync.sv ----
`timescale 1ns/1ps
module trigger_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous level
	input wire logic asyncIn,
	// Synchronised rising edge
	output logic risePulse
);

	logic [2:0] stage_reg;
	logic level_reg;

	// Three stages; change accepted once the last two agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage_reg <= 3'h0;
			level_reg <= 1'b0;
			risePulse <= 1'b0;
		end
		else
		begin
			stage_reg <= {stage_reg[1:0], asyncIn};
			risePulse <= 1'b0;
			if (stage_reg[2] == stage_reg[1])
			begin
				level_reg <= stage_reg[2];
				risePulse <= stage_reg[2] && !level_reg;
			end
		end
	end

endmodule : trigger_sync

// ---- rtl/sar_adc_control_front_end.sv ----
`timescale 1ns/1ps
module sar_adc_control_front_end
#(
	parameter int CHANNELS = 8,
	parameter int RAW_WIDTH = adc_front_pkg::RAW_BITS_10
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regReadData,
	// Clock sources as enables on clk
	input wire logic alternateClockTick,
	input wire logic asyncClockTick,
	input wire logic lowPowerWait,
	// Hardware trigger
	input wire logic hardware_trigger_input,
	// Comparator of the analog array
	input wire logic comparatorHigh,
	// Analog array control
	output logic converterEnable,
	output logic asyncClockEnable,
	output logic sampleActive,
	output logic [RAW_WIDTH-1:0] trialCode,
	output logic [4:0] channelSelect,
	output logic completionIrq,
	// Pin control
	input wire logic [CHANNELS-1:0] pinInput,
	input wire logic [CHANNELS-1:0] portOutEnable,
	input wire logic [CHANNELS-1:0] portPullup,
	output logic [CHANNELS-1:0] pinOutEnable,
	output logic [CHANNELS-1:0] pinPullup,
	output logic [CHANNELS-1:0] portReadData
);

	typedef enum {IDLE, STARTUP, SAMPLE, CONVERT, FINISH} state_type;

	// ****************************************
	// Registers
	// ****************************************
	state_type state_reg;
	adc_front_pkg::status_ctrl_type statusCtrl_reg;
	adc_front_pkg::config_type config_reg;
	adc_front_pkg::trigger_ctrl_type trigCtrl_reg;
	logic [7:0] analog_pin_disable_high;
	logic [7:0] resultHigh_reg;
	logic [7:0] resultLow_reg;
	logic [7:0] compareHigh_reg;
	logic [7:0] compareLow_reg;
	logic conversion_done_flag;
	logic [RAW_WIDTH-1:0] raw_reg;
	logic [3:0] bitIndex_reg;
	logic [12:0] waitCount_reg;
	logic softStart;
	logic modeChange;
	logic hwRise;
	logic convTick;
	logic sourceTick;
	logic moduleOff;
	logic busy;
	logic hwStart;
	logic startReq;
	logic tenBit;
	logic [RAW_WIDTH-1:0] rawNext;
	logic [9:0] rounded;
	logic [9:0] compareValue;
	logic [10:0] difference;
	logic compareHit;
	logic [3:0] lastBit;
	state_type startState;

	// ****************************************
	// Helpers
	// ****************************************
	trigger_sync trigSync
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(hardware_trigger_input),
		.risePulse(hwRise)
	);

	always_comb
	begin
		case (config_reg.source)
			adc_front_pkg::CLKSRC_BUS: sourceTick = 1'b1;
			adc_front_pkg::CLKSRC_BUS_HALF: sourceTick = 1'b1;
			adc_front_pkg::CLKSRC_ALT: sourceTick = alternateClockTick;
			default: sourceTick = asyncClockTick;
		endcase
	end

	clock_divider divider
	(
		.clk(clk),
		.rst_n(rst_n),
		.run(busy),
		.halfSource(config_reg.source == adc_front_pkg::CLKSRC_BUS_HALF),
		.divider(config_reg.divider),
		.sourceTick(sourceTick),
		.convTick(convTick)
	);

	assign moduleOff = statusCtrl_reg.channel == adc_front_pkg::CHANNEL_ALL_ONES;
	assign busy = state_reg != IDLE;
	assign tenBit = config_reg.mode == adc_front_pkg::MODE_10BIT;
	assign softStart = regWrite && regAddr == adc_front_pkg::STATUS_CTRL_ADDR;
	assign modeChange = regWrite && (regAddr == adc_front_pkg::CONFIG_ADDR
		|| regAddr == adc_front_pkg::TRIGGER_CTRL_ADDR
		|| regAddr == adc_front_pkg::COMPARE_HIGH_ADDR
		|| regAddr == adc_front_pkg::COMPARE_LOW_ADDR);
	// Edges during a conversion or a running sequence never start one
	assign hwStart = trigCtrl_reg.hardwareTrigger && hwRise && !busy;
	// Start write judged by the channel it writes, not the old one
	assign startReq = trigCtrl_reg.hardwareTrigger ? hwStart && !moduleOff
		: softStart && regWriteData[4:0] != adc_front_pkg::CHANNEL_ALL_ONES;
	assign startState = (config_reg.source == adc_front_pkg::CLKSRC_ASYNC)
		? STARTUP : SAMPLE;
	// 8-bit mode runs the top nine trial bits, code stays full-scale aligned
	assign lastBit = tenBit ? 4'h0
		: 4'(adc_front_pkg::RAW_BITS_10 - adc_front_pkg::RAW_BITS_8);

	// Trial bit: keep current bit if comparator says input is higher
	always_comb
	begin
		rawNext = raw_reg;
		rawNext[bitIndex_reg] = comparatorHigh;
	end

	// Comparator must see the trial code in the cycle it is set
	assign trialCode = raw_reg;

	// Round half up, saturating at full scale
	always_comb
	begin
		if (tenBit)
			rounded = (raw_reg[10:1] == 10'h3FF) ? 10'h3FF
				: raw_reg[10:1] + {9'h000, raw_reg[0]};
		else
			rounded = (raw_reg[10:3] == 8'hFF) ? 10'h0FF
				: {2'h0, raw_reg[10:3] + {7'h00, raw_reg[2]}};
	end

	assign compareValue = tenBit ? {compareHigh_reg[1:0], compareLow_reg}
		: {2'h0, compareLow_reg};
	assign difference = {1'b0, rounded} + {1'b1, ~compareValue} + 11'h001;
	// Sign bit set means the result is below the compare value
	assign compareHit = trigCtrl_reg.greaterEqual ? !difference[10] : difference[10];

	// ****************************************
	// Conversion sequence
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= IDLE;
			raw_reg <= '0;
			bitIndex_reg <= 4'h0;
			waitCount_reg <= 13'h0000;
		end
		else if (moduleOff || modeChange || softStart)
		begin
			state_reg <= (startReq && !modeChange) ? startState : IDLE;
			raw_reg <= '0;
			waitCount_reg <= 13'h0000;
		end
		else
		begin
			case (state_reg)
				IDLE:
					if (startReq)
						state_reg <= startState;
				STARTUP:
					if (waitCount_reg == 13'(adc_front_pkg::ASYNC_STARTUP_CYCLES - 1))
					begin
						waitCount_reg <= 13'h0000;
						state_reg <= SAMPLE;
					end
					else
						waitCount_reg <= waitCount_reg + 13'h0001;
				SAMPLE:
					if (convTick)
					begin
						raw_reg <= '0;
						bitIndex_reg <= 4'(RAW_WIDTH - 1);
						raw_reg[RAW_WIDTH - 1] <= 1'b1;
						state_reg <= CONVERT;
					end
				CONVERT:
					if (convTick)
					begin
						raw_reg <= rawNext;
						if (bitIndex_reg == lastBit)
							state_reg <= FINISH;
						else
						begin
							raw_reg[bitIndex_reg - 4'h1] <= 1'b1;
							bitIndex_reg <= bitIndex_reg - 4'h1;
						end
					end
				default:
					state_reg <= (statusCtrl_reg.continuous
						&& !(trigCtrl_reg.compareEnable && !compareHit && !statusCtrl_reg.continuous))
						? SAMPLE : IDLE;
			endcase
		end
	end

	// ****************************************
	// Result and completion flag
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resultHigh_reg <= 8'h00;
			resultLow_reg <= 8'h00;
			conversion_done_flag <= 1'b0;
		end
		else if (state_reg == FINISH && !moduleOff && !modeChange
			&& (!trigCtrl_reg.compareEnable || compareHit))
		begin
			if (tenBit)
				resultHigh_reg <= {6'h00, rounded[9:8]};
			else
				resultHigh_reg <= 8'h00;
			resultLow_reg <= rounded[7:0];
			conversion_done_flag <= 1'b1;
		end
		else if (softStart || (regRead && regAddr == adc_front_pkg::RESULT_LOW_ADDR))
			conversion_done_flag <= 1'b0;
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			statusCtrl_reg <= '{channel: adc_front_pkg::CHANNEL_ALL_ONES,
				irqEnable: 1'b0, continuous: 1'b0};
			config_reg <= '{divider: adc_front_pkg::DIV_BY_1,
				mode: adc_front_pkg::MODE_8BIT, source: adc_front_pkg::CLKSRC_BUS};
			trigCtrl_reg <= '0;
			compareHigh_reg <= 8'h00;
			compareLow_reg <= 8'h00;
			analog_pin_disable_high <= adc_front_pkg::PIN_DISABLE_RESET;
		end
		else if (regWrite)
		begin
			if (regAddr == adc_front_pkg::STATUS_CTRL_ADDR)
				statusCtrl_reg <= regWriteData[6:0];
			else if (regAddr == adc_front_pkg::CONFIG_ADDR)
				config_reg <= regWriteData[5:0];
			else if (regAddr == adc_front_pkg::TRIGGER_CTRL_ADDR)
				trigCtrl_reg <= regWriteData[2:0];
			else if (regAddr == adc_front_pkg::COMPARE_HIGH_ADDR)
				compareHigh_reg <= regWriteData;
			else if (regAddr == adc_front_pkg::COMPARE_LOW_ADDR)
				compareLow_reg <= regWriteData;
			else if (regAddr == adc_front_pkg::PIN_DISABLE_HIGH_ADDR)
				analog_pin_disable_high <= regWriteData;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			regReadData <= 8'h00;
		else if (!regRead)
			regReadData <= 8'h00;
		else if (regAddr == adc_front_pkg::STATUS_CTRL_ADDR)
			regReadData <= {conversion_done_flag, statusCtrl_reg};
		else if (regAddr == adc_front_pkg::CONFIG_ADDR)
			regReadData <= {2'h0, config_reg};
		else if (regAddr == adc_front_pkg::TRIGGER_CTRL_ADDR)
			regReadData <= {busy, 4'h0, trigCtrl_reg};
		else if (regAddr == adc_front_pkg::RESULT_HIGH_ADDR)
			regReadData <= resultHigh_reg;
		else if (regAddr == adc_front_pkg::RESULT_LOW_ADDR)
			regReadData <= resultLow_reg;
		else if (regAddr == adc_front_pkg::COMPARE_HIGH_ADDR)
			regReadData <= compareHigh_reg;
		else if (regAddr == adc_front_pkg::COMPARE_LOW_ADDR)
			regReadData <= compareLow_reg;
		else if (regAddr == adc_front_pkg::PIN_DISABLE_HIGH_ADDR)
			regReadData <= analog_pin_disable_high;
		else
			regReadData <= 8'h00;
	end

	// ****************************************
	// Outputs to the analog array
	// ****************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			converterEnable <= 1'b0;
			asyncClockEnable <= 1'b0;
			sampleActive <= 1'b0;
			channelSelect <= adc_front_pkg::CHANNEL_ALL_ONES;
			completionIrq <= 1'b0;
		end
		else
		begin
			converterEnable <= busy && !moduleOff;
			// Async source stays on through low-power waits
			asyncClockEnable <= busy && config_reg.source == adc_front_pkg::CLKSRC_ASYNC
				&& (lowPowerWait || !lowPowerWait);
			sampleActive <= state_reg == SAMPLE;
			channelSelect <= statusCtrl_reg.channel;
			completionIrq <= conversion_done_flag && statusCtrl_reg.irqEnable;
		end
	end

	// ****************************************
	// Pin control
	// ****************************************
	// Pins beyond the eighth register bit are disabled by register bit n % 8
	for (genvar n = 0; n < CHANNELS; n++)
	begin : pinGen
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				pinOutEnable[n] <= 1'b0;
				pinPullup[n] <= 1'b0;
				portReadData[n] <= 1'b0;
			end
			else if (analog_pin_disable_high[n % 8])
			begin
				pinOutEnable[n] <= 1'b0;
				pinPullup[n] <= 1'b0;
				portReadData[n] <= 1'b0;
			end
			else
			begin
				pinOutEnable[n] <= portOutEnable[n];
				pinPullup[n] <= portPullup[n];
				portReadData[n] <= pinInput[n];
			end
		end
	end

endmodule : sar_adc_control_front_end

// ---- test/sar_adc_front_sva.sv ----
`timescale 1ns/1ps
module sar_adc_front_sva
#(
	parameter int CHANNELS = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regReadData,
	// Converter
	input wire logic converterEnable,
	input wire logic asyncClockEnable,
	input wire logic completionIrq,
	input wire logic [4:0] channelSelect,
	input wire logic sampleActive,
	// Pins
	input wire logic [CHANNELS-1:0] pinInput,
	input wire logic [CHANNELS-1:0] portOutEnable,
	input wire logic [CHANNELS-1:0] portPullup,
	input wire logic [CHANNELS-1:0] pinOutEnable,
	input wire logic [CHANNELS-1:0] pinPullup,
	input wire logic [CHANNELS-1:0] portReadData
);
	// ****
	// Shadow of written fields
	// ****
	logic [7:0] disReg;
	logic [1:0] srcReg;
	logic irqReg;
	logic contReg;
	logic [CHANNELS-1:0] dis;
	assign dis = CHANNELS'(disReg);
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			disReg <= 8'h00;
			srcReg <= 2'h0;
			{contReg, irqReg} <= 2'h0;
		end
		else if (regWrite)
			case (regAddr)
				4'h0: {contReg, irqReg} <= regWriteData[6:5];
				4'h1: srcReg <= regWriteData[1:0];
				4'h7: disReg <= regWriteData;
				default: ;
			endcase
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_off_ones: assert property (
		channelSelect == 5'h1F [*2] |-> !converterEnable)
		else $error("Converter active on channel all ones");
	a_read_quiet: assert property (!regRead |=> regReadData == 8'h00)
		else $error("Read data without read strobe");
	a_read_unmapped: assert property (
		regRead && regAddr > 4'h7 |=> regReadData == 8'h00)
		else $error("Unmapped read not zero");
	a_pin_drive: assert property (
		1 |=> pinOutEnable == ($past(portOutEnable) & ~$past(dis)))
		else $error("Pin driver not forced off");
	a_pin_pullup: assert property (
		1 |=> pinPullup == ($past(portPullup) & ~$past(dis)))
		else $error("Pin pullup not forced off");
	a_pin_read: assert property (
		1 |=> portReadData == ($past(pinInput) & ~$past(dis)))
		else $error("Disabled pin read not zero");
	a_async_source: assert property (
		asyncClockEnable |-> $past(srcReg) == 2'h3)
		else $error("Async clock on with other source");
	a_irq_mask: assert property (completionIrq |-> $past(irqReg))
		else $error("Interrupt while disabled");
	a_irq_clear: assert property (
		regRead && regAddr == 4'h4 && !converterEnable |-> ##2 !completionIrq)
		else $error("Done not cleared by result read");
	a_idle_done: assert property (
		$rose(completionIrq) && !contReg |=> !converterEnable)
		else $error("Converter not idle after completion");
	a_sample_busy: assert property (sampleActive |-> converterEnable)
		else $error("Sampling while converter disabled");
	c_continuous: cover property ($rose(completionIrq) && contReg);
	c_done: cover property (completionIrq);
	c_async: cover property (asyncClockEnable);
	c_unmapped: cover property (regRead && regAddr > 4'h7);
endmodule : sar_adc_front_sva

bind sar_adc_control_front_end sar_adc_front_sva #(.CHANNELS(CHANNELS)) chk
(
	.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
	.regReadData(regReadData), .converterEnable(converterEnable),
	.asyncClockEnable(asyncClockEnable), .completionIrq(completionIrq),
	.channelSelect(channelSelect), .sampleActive(sampleActive),
	.pinInput(pinInput),
	.portOutEnable(portOutEnable), .portPullup(portPullup),
	.pinOutEnable(pinOutEnable), .pinPullup(pinPullup),
	.portReadData(portReadData)
);

// ---- test/analog_side_model.sv ----
`timescale 1ns/1ps
module analog_side_model
#(
	parameter int RAW_WIDTH = 11
)
(
	// Trial code from the converter
	input wire logic [RAW_WIDTH-1:0] trialCode,
	// Held channel level
	input wire logic [RAW_WIDTH-1:0] level,
	// Comparator decision
	output logic comparatorHigh
);
	// Ideal comparator, no offset or noise modelled
	assign comparatorHigh = level >= trialCode;
endmodule : analog_side_model

// ---- test/tb_sar_adc_control_front_end.sv ----
`timescale 1ns/1ps
module tb_sar_adc_control_front_end;
	logic clk;
	logic rst_n;
	logic [3:0] regAddr;
	logic [7:0] regWriteData;
	logic regWrite, regRead;
	logic [7:0] regReadData;
	logic alternateClockTick, asyncClockTick, lowPowerWait, trigIn;
	logic comparatorHigh, converterEnable, asyncClockEnable, completionIrq;
	logic [10:0] trialCode;
	logic [10:0] level;
	logic [4:0] channelSelect;
	logic [7:0] pinInput, portOutEnable, portPullup;
	logic [7:0] pinOutEnable, pinPullup, portReadData;
	logic [31:0] seed = 32'h0000000F;
	logic [31:0] tmp;
	logic [7:0] hi, lo, st;
	logic [4:0] ch;
	int fails = 0;
	int testsRun = 0;
	int cycles = 0;
	int dur, need;

	sar_adc_control_front_end #(.CHANNELS(8), .RAW_WIDTH(11)) dut
	(
		.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.regReadData(regReadData), .alternateClockTick(alternateClockTick),
		.asyncClockTick(asyncClockTick), .lowPowerWait(lowPowerWait),
		.hardware_trigger_input(trigIn), .comparatorHigh(comparatorHigh),
		.converterEnable(converterEnable), .sampleActive(),
		.asyncClockEnable(asyncClockEnable), .trialCode(trialCode),
		.channelSelect(channelSelect), .completionIrq(completionIrq),
		.pinInput(pinInput), .portOutEnable(portOutEnable),
		.portPullup(portPullup), .pinOutEnable(pinOutEnable),
		.pinPullup(pinPullup), .portReadData(portReadData)
	);
	analog_side_model #(.RAW_WIDTH(11)) partner
	(
		.trialCode(trialCode), .level(level), .comparatorHigh(comparatorHigh)
	);

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Ideal comparator: raw is the level, 8-bit keeps its top nine bits
	// Round half up, saturating at full scale
	function automatic logic [15:0] expResult(logic [1:0] m, logic [10:0] v);
		logic [11:0] r;
		if (m == adc_front_pkg::MODE_10BIT)
		begin
			r = ({1'b0, v} + 12'h001) >> 1;
			return (r > 12'h3FF) ? 16'h03FF : {4'h0, r};
		end
		r = ({3'h0, v[10:2]} + 12'h001) >> 1;
		return (r > 12'h0FF) ? 16'h00FF : {4'h0, r};
	endfunction : expResult
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regReadData;
	endtask : rd
	task automatic waitIrq(output int n);
		n = 0;
		while (completionIrq !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check({15'h0, completionIrq}, 16'h0001);
	endtask : waitIrq
	task automatic pulse();
		@(posedge clk);
		trigIn <= 1'b1;
		repeat (4) @(posedge clk);
		trigIn <= 1'b0;
	endtask : pulse

	// ****
	// Clock and free-running stimulus
	// ****
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		logic [31:0] r;
		r = xs();
		cycles <= cycles + 1;
		alternateClockTick <= cycles % 3 == 0;
		asyncClockTick <= cycles[0];
		lowPowerWait <= r[24];
		{pinInput, portOutEnable, portPullup} <= r[23:0];
		if (cycles == 90000)
		begin
			fails++;
			conclude();
		end
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		rst_n = 1'b0;
		{regAddr, regWriteData, regWrite, regRead, trigIn} = '0;
		{alternateClockTick, asyncClockTick, lowPowerWait} = '0;
		{pinInput, portOutEnable, portPullup} = '0;
		level = 11'h000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		check({11'h000, channelSelect}, 16'h001F);
		check({15'h0, converterEnable}, 16'h0000);
		rd(4'h1, st);
		check({14'h0, st[1:0]}, 16'h0000);
		rd(4'h7, st);
		check({8'h00, st}, {8'h00, adc_front_pkg::PIN_DISABLE_RESET});
		for (int a = 8; a < 16; a++)
		begin
			rd(4'(a), st);
			check({8'h00, st}, 16'h0000);
		end
		// Pin disable, all ones first
		for (int k = 0; k < 4; k++)
		begin
			tmp = xs();
			if (k == 0)
				tmp[7:0] = 8'hFF;
			wr(4'h7, tmp[7:0]);
			rd(4'h7, st);
			check({8'h00, st}, {8'h00, tmp[7:0]});
			check({8'h00, portReadData & st}, 16'h0000);
		end
		// Every source, divider and mode
		for (int s = 0; s < 4; s++)
			for (int d = 0; d < 4; d++)
				for (int m = 0; m < 4; m += 2)
				begin
					tmp = xs();
					level <= tmp[10:0];
					ch = tmp[15:11];
					if (ch == 5'h1F)
						ch = 5'h00;
					wr(4'h1, {2'b00, d[1:0], m[1:0], s[1:0]});
					wr(4'h0, {3'b001, ch});
					waitIrq(dur);
					need = (m == 2 ? 11 : 9) * ((s == 1 ? 2 : 1) << d);
					if (s < 2)
						check({15'h0, dur >= need}, 16'h0001);
					check({11'h000, channelSelect}, {11'h000, ch});
					rd(4'h0, st);
					check({15'h0, st[7]}, 16'h0001);
					rd(4'h3, hi);
					rd(4'h4, lo);
					check({hi, lo}, expResult(m[1:0], level));
				end
		// Compare false stays idle, compare true completes
		level <= 11'h008;
		wr(4'h5, 8'h03);
		wr(4'h6, 8'hFF);
		wr(4'h2, 8'h06);
		wr(4'h1, 8'h08);
		wr(4'h0, 8'h25);
		repeat (3000) @(posedge clk);
		#1;
		check({14'h0, completionIrq, converterEnable}, 16'h0000);
		wr(4'h2, 8'h04);
		wr(4'h0, 8'h25);
		waitIrq(dur);
		rd(4'h4, lo);
		// Hardware trigger, second edge while busy
		level <= 11'h550;
		wr(4'h2, 8'h01);
		pulse();
		pulse();
		waitIrq(dur);
		rd(4'h3, hi);
		rd(4'h4, lo);
		check({hi, lo}, expResult(2'h2, 11'h550));
		repeat (200) @(posedge clk);
		#1;
		check({14'h0, completionIrq, converterEnable}, 16'h0000);
		wr(4'h2, 8'h00);
		pulse();
		repeat (50) @(posedge clk);
		#1;
		check({15'h0, converterEnable}, 16'h0000);
		// Continuous run from one edge, later edges leave it running
		wr(4'h2, 8'h01);
		wr(4'h0, 8'h65);
		pulse();
		waitIrq(dur);
		rd(4'h4, lo);
		pulse();
		waitIrq(dur);
		check({15'h0, converterEnable}, 16'h0001);
		// Channel all ones stops the module
		wr(4'h0, 8'h1F);
		repeat (20) @(posedge clk);
		#1;
		check({15'h0, converterEnable}, 16'h0000);
		rd(4'h0, st);
		check({15'h0, st[7]}, 16'h0000);
		conclude();
	end
endmodule : tb_sar_adc_control_front_end
